// file: core/fpe_ctrl.sv
// Purpose: APB controller sequencing program and erase of the array
// Assumes: Software follows the ordered steps and hold times
// Notes:   Zero-wait APB slave; pready and prdata are registered
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fpe_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             charge_pump_on,
  output logic             array_hv_on
);
  fpe_mem_if mif ();

  fpe_array_mem u_mem (
    .clk (pclk),
    .m   (mif.mem)
  );

  logic                prog_q;
  logic                erase_q;
  logic                whole_q;
  logic                hv_q;
  fpe_pkg::fpe_state_t st_q;
  logic [10:0]         cnt_q;
  logic [15:0]         addr_q;
  logic [15:0]         lat_addr_q;
  logic                er_busy_q;
  logic [12:0]         er_idx_q;
  logic [12:0]         er_left_q;
  logic                pump_q;
  logic                hvout_q;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_ctrl;
  logic        wr_data;
  logic [3:0]  v;
  logic        both_sel;
  logic [15:0] prot_start;
  logic        blocked;
  logic        hv_ok;
  logic        in_array;
  logic [15:0] idx_full;
  logic [15:0] lat_full;
  logic        prog_wr;
  logic        mapped;

  assign acc      = psel & penable & pready;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign wr_ctrl  = wr & (paddr == fpe_pkg::FPE_OFF_CTRL);
  assign wr_data  = wr & (paddr == fpe_pkg::FPE_OFF_DATA);
  assign v        = pwdata[3:0];
  assign both_sel = v[fpe_pkg::FPE_BIT_ERASE] & v[fpe_pkg::FPE_BIT_PROG];
  assign mapped   = (paddr == fpe_pkg::FPE_OFF_CTRL) | (paddr == fpe_pkg::FPE_OFF_PROT) |
                    (paddr == fpe_pkg::FPE_OFF_ADDR) | (paddr == fpe_pkg::FPE_OFF_DATA) |
                    (paddr == fpe_pkg::FPE_OFF_STAT);

  // Array occupies user range plus the top page group
  assign in_array = ((addr_q >= fpe_pkg::FPE_USER_LO) && (addr_q <= fpe_pkg::FPE_USER_HI)) ||
                    (addr_q >= fpe_pkg::FPE_VPAGE_LO);
  assign idx_full = addr_q - fpe_pkg::FPE_USER_LO;
  assign lat_full = {lat_addr_q[15:6], 6'h00} - fpe_pkg::FPE_USER_LO;

  assign prot_start = {2'b11, mif.prot_byte, 6'h00};
  assign blocked    = whole_q ? (mif.prot_byte != fpe_pkg::FPE_ERASED)
                              : (lat_addr_q >= prot_start);
  assign hv_ok      = (st_q == fpe_pkg::FPE_ST_ARMED) && !blocked &&
                      (v[fpe_pkg::FPE_BIT_ERASE] | v[fpe_pkg::FPE_BIT_PROG]) &&
                      !(v[fpe_pkg::FPE_BIT_WHOLE] & ~v[fpe_pkg::FPE_BIT_ERASE]);

  // Program data only lands after setup time, inside the latched row
  assign prog_wr = wr_data && prog_q && hv_q && (st_q == fpe_pkg::FPE_ST_HV) &&
                   (cnt_q >= fpe_pkg::FPE_PGS_CYC) && in_array &&
                   (addr_q[15:5] == lat_addr_q[15:5]);

  // APB answer: registered in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped |
                 (pwrite & (paddr == fpe_pkg::FPE_OFF_CTRL) & both_sel));
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          fpe_pkg::FPE_OFF_CTRL: prdata <= {28'h0000000, hv_q, whole_q, erase_q, prog_q};
          fpe_pkg::FPE_OFF_PROT: prdata <= {24'h000000, mif.prot_byte};
          fpe_pkg::FPE_OFF_ADDR: prdata <= {16'h0000, addr_q};
          fpe_pkg::FPE_OFF_DATA: prdata <= in_array ? {24'h000000, mif.rd_data} : 32'h0000_0000;
          fpe_pkg::FPE_OFF_STAT: prdata <= {25'h0000000, er_busy_q, st_q};
          default:               prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; a write selecting both operations is dropped whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hv_q, whole_q, erase_q, prog_q} <= fpe_pkg::FPE_CTRL_RST;
    end else if (wr_ctrl && !both_sel) begin
      prog_q  <= v[fpe_pkg::FPE_BIT_PROG];
      erase_q <= v[fpe_pkg::FPE_BIT_ERASE];
      whole_q <= v[fpe_pkg::FPE_BIT_WHOLE];
      if (!v[fpe_pkg::FPE_BIT_HV]) begin
        hv_q <= 1'b0;
      end else if (!hv_q) begin
        hv_q <= hv_ok;
      end
    end
  end

  // Pump and array voltage follow the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_q  <= 1'b0;
      hvout_q <= 1'b0;
    end else begin
      pump_q  <= hv_q;
      hvout_q <= hv_q;
    end
  end
  assign charge_pump_on = pump_q;
  assign array_hv_on    = hvout_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= fpe_pkg::FPE_ADDR_RST;
    end else if (wr && (paddr == fpe_pkg::FPE_OFF_ADDR)) begin
      addr_q <= pwdata[15:0];
    end
  end

  // Step tracker; a select change outside HV restarts the order unless the same write is an allowed HV request from ARMED
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= fpe_pkg::FPE_ST_IDLE;
      cnt_q      <= 11'h000;
      lat_addr_q <= fpe_pkg::FPE_ADDR_RST;
    end else begin
      case (st_q)
        fpe_pkg::FPE_ST_HV: begin
          if (cnt_q < fpe_pkg::FPE_PGS_CYC) begin
            cnt_q <= cnt_q + 11'h001;
          end
          if (!hv_q) begin
            st_q <= (erase_q | prog_q) ? fpe_pkg::FPE_ST_SEL : fpe_pkg::FPE_ST_IDLE;
          end
        end
        default: begin
          if (wr_ctrl && !both_sel) begin
            if (hv_ok && v[fpe_pkg::FPE_BIT_HV]) begin
              st_q  <= fpe_pkg::FPE_ST_HV;
              cnt_q <= 11'h000;
            end else if (v[fpe_pkg::FPE_BIT_ERASE:fpe_pkg::FPE_BIT_PROG] !=
                         {erase_q, prog_q} ||
                         v[fpe_pkg::FPE_BIT_WHOLE] != whole_q) begin
              st_q <= (v[fpe_pkg::FPE_BIT_ERASE] | v[fpe_pkg::FPE_BIT_PROG]) ?
                      fpe_pkg::FPE_ST_SEL : fpe_pkg::FPE_ST_IDLE;
            end
          end else begin
            case (st_q)
              fpe_pkg::FPE_ST_IDLE: begin
                if (erase_q | prog_q) begin
                  st_q <= fpe_pkg::FPE_ST_SEL;
                end
              end
              fpe_pkg::FPE_ST_SEL: begin
                if (rd && (paddr == fpe_pkg::FPE_OFF_PROT)) begin
                  st_q <= fpe_pkg::FPE_ST_PROT;
                end
              end
              fpe_pkg::FPE_ST_PROT: begin
                // Address latch; program mode latches the target row
                if (wr_data && in_array) begin
                  st_q       <= fpe_pkg::FPE_ST_NVS;
                  lat_addr_q <= addr_q;
                  cnt_q      <= 11'h000;
                end
              end
              fpe_pkg::FPE_ST_NVS: begin
                if (cnt_q >= fpe_pkg::FPE_NVS_CYC - 11'h001) begin
                  st_q <= fpe_pkg::FPE_ST_ARMED;
                end else begin
                  cnt_q <= cnt_q + 11'h001;
                end
              end
              fpe_pkg::FPE_ST_ARMED: st_q <= fpe_pkg::FPE_ST_ARMED;
              default:               st_q <= fpe_pkg::FPE_ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // Erase engine: one byte per cycle, well inside the hold time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      er_busy_q <= 1'b0;
      er_idx_q  <= 13'h0000;
      er_left_q <= 13'h0000;
    end else if (!er_busy_q) begin
      if (wr_ctrl && !both_sel && v[fpe_pkg::FPE_BIT_HV] && !hv_q && hv_ok &&
          v[fpe_pkg::FPE_BIT_ERASE]) begin
        er_busy_q <= 1'b1;
        er_idx_q  <= v[fpe_pkg::FPE_BIT_WHOLE] ? 13'h0000 : lat_full[12:0];
        er_left_q <= (v[fpe_pkg::FPE_BIT_WHOLE] ? fpe_pkg::FPE_ALL_BYTES
                                                : fpe_pkg::FPE_PAGE_BYTES) - 13'h0001;
      end
    end else begin
      er_idx_q  <= er_idx_q + 13'h0001;
      er_left_q <= er_left_q - 13'h0001;
      if (er_left_q == 13'h0000) begin
        er_busy_q <= 1'b0;
      end
    end
  end

  always_comb begin
    mif.wr_en    = er_busy_q | prog_wr;
    mif.wr_erase = er_busy_q;
    mif.wr_idx   = er_busy_q ? er_idx_q : idx_full[12:0];
    mif.wr_data  = pwdata[7:0];
    mif.rd_idx   = idx_full[12:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hv_rise;
    $rose(hv_q);
  endsequence

  sequence s_page_run;
    ##63 er_busy_q ##1 !er_busy_q;
  endsequence

  AST_NO_BOTH: assert property (!(erase_q && prog_q))
    else $error("erase and program selected together");
  AST_BOTH_REFUSED: assert property (wr_ctrl && both_sel |=> $stable({erase_q, prog_q}))
    else $error("write selecting both operations took effect");
  AST_HV_ORDER: assert property (s_hv_rise |-> $past(st_q) == fpe_pkg::FPE_ST_ARMED && (erase_q || prog_q))
    else $error("high voltage set out of sequence");
  AST_PUMP: assert property (hv_q |=> charge_pump_on && array_hv_on)
    else $error("pump not following enable");
  AST_WHOLE_BLOCK: assert property ($rose(hv_q) && whole_q |-> $past(mif.prot_byte) == fpe_pkg::FPE_ERASED)
    else $error("whole erase started while protected");
  AST_PROTECT: assert property ($rose(hv_q) && !whole_q |-> $past(lat_addr_q) < $past(prot_start))
    else $error("protected target got high voltage");
  AST_PAGE_LEN: assert property ($rose(er_busy_q) && !whole_q |-> s_page_run)
    else $error("page erase length wrong");
  AST_ROW: assert property (mif.wr_en && !mif.wr_erase |-> addr_q[15:5] == lat_addr_q[15:5])
    else $error("program outside latched row");
  AST_CTRL_UPPER: assert property (psel && !penable && !pwrite && paddr == fpe_pkg::FPE_OFF_CTRL |=> prdata[31:4] == 28'h0000000)
    else $error("control upper bits not zero");
endmodule // fpe_ctrl
`default_nettype wire

// file: core/fpe_pkg.sv
// Purpose: Shared constants for the nonvolatile array program/erase controller
// Assumes: APB register access, 200 MHz pclk
// Notes:   Array store indexes 0xEE00..0xFFFF; the window reaches 0xEE00..0xFDFF and 0xFF80..0xFFFF
package fpe_pkg;
  // Register byte offsets
  localparam logic [11:0] FPE_OFF_CTRL  = 12'h000;
  localparam logic [11:0] FPE_OFF_PROT  = 12'h004;
  localparam logic [11:0] FPE_OFF_ADDR  = 12'h008;
  localparam logic [11:0] FPE_OFF_DATA  = 12'h00C;
  localparam logic [11:0] FPE_OFF_STAT  = 12'h010;
  // Control register fields
  localparam int          FPE_BIT_PROG  = 0;
  localparam int          FPE_BIT_ERASE = 1;
  localparam int          FPE_BIT_WHOLE = 2;
  localparam int          FPE_BIT_HV    = 3;
  localparam logic [3:0]  FPE_CTRL_RST  = 4'h0;
  // Array map
  localparam logic [15:0] FPE_USER_LO   = 16'hEE00;
  localparam logic [15:0] FPE_USER_HI   = 16'hFDFF;
  localparam logic [15:0] FPE_VPAGE_LO  = 16'hFF80;
  localparam logic [15:0] FPE_PROT_ADDR = 16'hFFBE;
  localparam logic [15:0] FPE_TRIM_ADDR = 16'hFFC0;
  localparam logic [15:0] FPE_VEC_LO    = 16'hFFD0;
  localparam int          FPE_IDX_W     = 13;
  localparam int          FPE_ARR_DEPTH = 4608;
  localparam logic [12:0] FPE_PROT_IDX  = 13'h11BE;
  localparam logic [12:0] FPE_PAGE_BYTES = 13'h0040;
  localparam logic [12:0] FPE_ALL_BYTES = 13'h1200;
  localparam logic [7:0]  FPE_ERASED    = 8'hFF;
  localparam logic [15:0] FPE_ADDR_RST  = 16'h0000;
  // Timing
  localparam int          FPE_CLK_MHZ   = 200;
  localparam int          FPE_NVS_US    = 10;
  localparam int          FPE_PGS_US    = 5;
  localparam logic [10:0] FPE_NVS_CYC   = 11'(FPE_NVS_US * FPE_CLK_MHZ);
  localparam logic [10:0] FPE_PGS_CYC   = 11'(FPE_PGS_US * FPE_CLK_MHZ);
  typedef enum logic [5:0] {
    FPE_ST_IDLE  = 6'b000001,
    FPE_ST_SEL   = 6'b000010,
    FPE_ST_PROT  = 6'b000100,
    FPE_ST_NVS   = 6'b001000,
    FPE_ST_ARMED = 6'b010000,
    FPE_ST_HV    = 6'b100000
  } fpe_state_t;
endpackage

// file: core/fpe_mem_if.sv
// Purpose: Port bundle between sequencer and array store
// Assumes: One write port, one registered read port
// Notes:   Erase writes force the byte to all ones
`timescale 1ns/1ps
`default_nettype none
interface fpe_mem_if;
  logic        wr_en;
  logic        wr_erase;
  logic [12:0] wr_idx;
  logic [7:0]  wr_data;
  logic [12:0] rd_idx;
  logic [7:0]  rd_data;
  logic [7:0]  prot_byte;
  modport ctrl (output wr_en, output wr_erase, output wr_idx, output wr_data,
                output rd_idx, input rd_data, input prot_byte);
  modport mem  (input wr_en, input wr_erase, input wr_idx, input wr_data,
                input rd_idx, output rd_data, output prot_byte);
endinterface
`default_nettype wire

// file: core/fpe_array_mem.sv
// Purpose: Array store with erase and bit-clearing program writes
// Assumes: Contents are nonvolatile, so no reset
// Notes:   Read data and protect byte come from registers
`timescale 1ns/1ps
`default_nettype none
module fpe_array_mem (
  input wire logic clk,
  fpe_mem_if.mem   m
);
  // Parts leave the factory erased; without this the protect byte is unknown
  logic [7:0] mem_q [fpe_pkg::FPE_ARR_DEPTH] = '{default: fpe_pkg::FPE_ERASED};

  // Programming can only clear bits; erase restores ones
  always_ff @(posedge clk) begin
    if (m.wr_en) begin
      mem_q[m.wr_idx] <= m.wr_erase ? fpe_pkg::FPE_ERASED : (mem_q[m.wr_idx] & m.wr_data);
    end
  end

  always_ff @(posedge clk) begin
    m.rd_data   <= mem_q[m.rd_idx];
    m.prot_byte <= mem_q[fpe_pkg::FPE_PROT_IDX];
  end
endmodule // fpe_array_mem
`default_nettype wire

// file: verif/fpe_apb_master.sv
// Purpose: APB master model standing in for software outside the array
// Assumes: Slave may add wait states; pready sampled at the rising edge
// Notes:   Address and data are inverted while idle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module fpe_apb_master (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // Called from bench code only, never from inside the array
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // fpe_apb_master
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the program/erase controller
// Assumes: Design counts 2000 and 1000 cycles for the setup waits
// Notes:   Array starts erased; the vector page erase runs first
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        charge_pump_on, array_hv_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, checks_done, cycles;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  fpe_apb_master i_fpe_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  fpe_ctrl i_fpe_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .charge_pump_on(charge_pump_on), .array_hv_on(array_hv_on));
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run needs about 50k cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_fpe_apb_master.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    i_fpe_apb_master.xfer(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, exp)
  endtask
  task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
    wr(fpe_pkg::FPE_OFF_ADDR, {16'h0000, a});
    wr(fpe_pkg::FPE_OFF_DATA, {24'h000000, d});
  endtask
  task automatic arr_chk(input logic [15:0] a, input logic [7:0] exp);
    wr(fpe_pkg::FPE_OFF_ADDR, {16'h0000, a});
    rd_chk(fpe_pkg::FPE_OFF_DATA, {24'h000000, exp});
  endtask
  // Select, protect read, latch write, setup wait, then ask for high voltage
  task automatic arm(input logic [3:0] sel, input logic [15:0] a, input logic [3:0] exp);
    wr(fpe_pkg::FPE_OFF_CTRL, {28'h0000000, sel});
    i_fpe_apb_master.xfer(1'b0, fpe_pkg::FPE_OFF_PROT, 32'h0000_0000, rd, err);
    arr_wr(a, 8'hFF);
    repeat (2000) @(posedge pclk);
    wr(fpe_pkg::FPE_OFF_CTRL, {28'h0000000, sel | 4'h8});
    rd_chk(fpe_pkg::FPE_OFF_CTRL, {28'h0000000, exp});
    `CHK({charge_pump_on, array_hv_on}, {exp[3], exp[3]})
  endtask
  // Selects drop first, high voltage after the hold time
  task automatic done_op(input int hold);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0008);
    repeat (hold) @(posedge pclk);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK({charge_pump_on, array_hv_on}, 2'b00)
  endtask
  task automatic t_regs();
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'hFFFF_FFF4);
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0004);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    rd_chk(12'h020, 32'h0000_0000);
    `CHK(err, 1'b1)
  endtask
  task automatic t_interlock();
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0002);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0003);
    `CHK(err, 1'b1)
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0002);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_000A);
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0002);
    `CHK({charge_pump_on, array_hv_on}, 2'b00)
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0001);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0003);
    rd_chk(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0001);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
  endtask
  // Erase hold shortened to 200 cycles: the engine needs 64, a full 1 ms is too long here
  task automatic t_vec_erase();
    arm(4'h2, 16'hFFBE, 4'hA);
    repeat (200) @(posedge pclk);
    done_op(1000);
    arr_chk(16'hFFBE, 8'hFF);
    arr_chk(16'hFFC0, 8'hFF);
    arr_chk(16'hFF80, 8'hFF);
    arr_chk(16'hFFFF, 8'hFF);
  endtask
  task automatic t_whole();
    arm(4'h6, 16'hEE00, 4'hE);
    repeat (4700) @(posedge pclk);
    done_op(20000);
    arr_chk(16'hEE00, 8'hFF);
    arr_chk(16'hFDFF, 8'hFF);
    arr_chk(16'hFE00, 8'h00);
  endtask
  task automatic t_prog();
    arm(4'h1, 16'hEE40, 4'h9);
    repeat (1000) @(posedge pclk);
    arr_wr(16'hEE45, 8'h3C);
    arr_wr(16'hEE25, 8'h00);
    done_op(1000);
    arr_chk(16'hEE45, 8'h3C);
    arr_chk(16'hEE25, 8'hFF);
  endtask
  task automatic t_protect();
    arm(4'h1, 16'hFFA0, 4'h9);
    repeat (1000) @(posedge pclk);
    arr_wr(16'hFFBE, 8'hFE);
    done_op(1000);
    rd_chk(fpe_pkg::FPE_OFF_PROT, 32'h0000_00FE);
    arm(4'h2, 16'hFFC0, 4'h2);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    arm(4'h6, 16'hEE00, 4'h6);
    wr(fpe_pkg::FPE_OFF_CTRL, 32'h0000_0000);
    arm(4'h2, 16'hEE7F, 4'hA);
    repeat (200) @(posedge pclk);
    done_op(1000);
    arr_chk(16'hEE45, 8'hFF);
    arr_chk(16'hFFC0, 8'hFF);
  endtask
  initial begin
    presetn = 1'b0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_interlock();
    t_vec_erase();
    t_whole();
    t_prog();
    t_protect();
    complete_run();
  end
endmodule // testbench
`undef CHK
`default_nettype wire
